/* File: core/step_seq_map.svh */
// Offsets, field positions, hold codes and timing counts of the step sequencer
`ifndef STEP_SEQ_MAP_SVH
`define STEP_SEQ_MAP_SVH
// Register offsets (index into a word-wide map)
`define SEQ_CTRL_OFS       4'h0
`define SEQ_STATUS_OFS     4'h1
`define SEQ_ENTRY_SEL_OFS  4'h2
`define SEQ_ENTRY_DATA_OFS 4'h3
`define SEQ_COUNT_OFS      4'h4
// Control bits: write one to trigger
`define CTRL_REMOVE_BIT    0
`define CTRL_APPEND_BIT    1
`define CTRL_CLEAR_BIT     2
// Entry word fields
`define ENT_STEP_LSB       0
`define ENT_STEP_MSB       6
`define ENT_SKIP_BIT       7
`define ENT_HOLD_LSB       8
`define ENT_HOLD_MSB       21
// Hold codes: values below TIMED_BASE are pass/fail pairs
`define HOLD_PH_FH         14'h0000
`define HOLD_PH_FS         14'h0001
`define HOLD_PH_FC         14'h0002
`define HOLD_PC_FH         14'h0003
`define HOLD_PC_FS         14'h0004
`define HOLD_PC_FC         14'h0005
`define HOLD_TIMED_BASE    14'h0010
// Timed hold span in tenths of a second: 0.1 s .. 999.9 s
`define HOLD_TENTHS_MIN    14'd1
`define HOLD_TENTHS_MAX    14'd9999
// Tick period in ns and derived cycle count at 40 MHz (25 ns)
`define TICK_NS            100000000
`define CLK_NS             25
`define TICK_CYCLES        (`TICK_NS / `CLK_NS)
`define STEP_NUM_MIN       7'd1
`define STEP_NUM_MAX       7'd100
`endif

/* File: core/step_seq_pkg.sv */
// Types for the automatic test step sequencer
`default_nettype none
package step_seq_pkg;
	typedef enum logic [2:0] {
		ST_READY = 3'b000,
		ST_FETCH = 3'b001,
		ST_RUN   = 3'b010,
		ST_HOLD  = 3'b011,
		ST_TIMED = 3'b100
	} seq_state_t;
endpackage : step_seq_pkg
`default_nettype wire

/* File: core/step_sequencer.sv */
// Automatic test step sequencer: entry list, hold actions, run control
// Notes on behaviour
// - Skip-flagged entries are passed over during runs
// - Remove request deletes selected entry, closing gap
// - Each entry holds a hold-action code
// - Pass with hold waits for START
// - Pass with continue advances automatically
// - Fail with hold waits for START
// - Fail with stop ends whole run
// - Fail with continue advances automatically
// - Timed hold waits programmed tenths, ignoring verdict
// - At most ten entries, steps 1 to 100
// - START begins run only when ready
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "step_seq_map.svh"
module step_sequencer
	import step_seq_pkg::*;
#(
	parameter int MAX_ENTRIES = 10,
	parameter int TICK_CYCLES = `TICK_CYCLES
)(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Register port
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Operator and measurement side (asynchronous pins)
	input  wire logic        start_i,
	input  wire logic        verdict_valid_i,
	input  wire logic        verdict_pass_i,
	// Step execution outputs
	output logic             step_go_o,
	output logic      [6:0]  stored_test_step_o,
	output logic             running_o,
	output logic             run_done_o,
	output logic             run_stopped_o
);
	localparam int IW = $clog2(MAX_ENTRIES + 1);
	localparam int CW = $clog2(TICK_CYCLES + 1);
	// Elaboration check: the index fields serve at most 15 entries
	if (MAX_ENTRIES < 1 || MAX_ENTRIES > 15 || TICK_CYCLES < 1)
	begin : g_bad_params
		$error("step_sequencer: unsupported parameter values");
	end

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		seq_state_t                   st;
		logic [MAX_ENTRIES-1:0][6:0]  step;
		logic [MAX_ENTRIES-1:0]       skip;
		logic [MAX_ENTRIES-1:0][13:0] hold;
		logic [IW-1:0]                count;
		logic [IW-1:0]                sel;
		logic [IW-1:0]                idx;
		logic [CW-1:0]                tick;
		logic [13:0]                  tenths;
		logic [2:0]                   start_sy;
		logic [1:0]                   vval_sy;
		logic [1:0]                   vpass_sy;
		logic                         vval_d;
		logic [31:0]                  rdata;
		logic                         go;
		logic [6:0]                   cur_step;
		logic                         done;
		logic                         stopped;
		logic                         running;
	} regs_t;

	regs_t r;
	regs_t next_r;

	logic start_rise;
	logic verdict_ev;
	assign start_rise = r.start_sy[1] & ~r.start_sy[2];
	assign verdict_ev = r.vval_sy[1] & ~r.vval_d;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: register port, list editing and run sequencing
	always_comb
	begin
		logic [13:0] h;
		logic        hold_it;
		logic        stop_it;
		h       = 14'h0000;
		hold_it = 1'b0;
		stop_it = 1'b0;
		next_r = r;
		next_r.go = 1'b0;
		// Pins pass two flops; third stage only feeds the edge detect
		next_r.start_sy = {r.start_sy[1:0], start_i};
		next_r.vval_sy  = {r.vval_sy[0], verdict_valid_i};
		next_r.vpass_sy = {r.vpass_sy[0], verdict_pass_i};
		next_r.vval_d   = r.vval_sy[1];
		// Read data valid only in the cycle after the strobe
		next_r.rdata = 32'h0000_0000;
		if (rd_i)
		begin
			case (addr_i)
				`SEQ_STATUS_OFS:    next_r.rdata = {24'h000000, r.done, r.stopped, 3'h0, r.st};
				`SEQ_ENTRY_SEL_OFS: next_r.rdata = {{(32-IW){1'b0}}, r.sel};
				`SEQ_ENTRY_DATA_OFS:
					if (r.sel < IW'(MAX_ENTRIES))
						next_r.rdata = {10'h000, r.hold[r.sel], r.skip[r.sel], r.step[r.sel]};
				`SEQ_COUNT_OFS:     next_r.rdata = {{(32-IW){1'b0}}, r.count};
				default:            next_r.rdata = 32'h0000_0000;
			endcase
		end
		// List edits only while ready, so a run never sees the list shift
		if (wr_i && r.st == ST_READY)
		begin
			case (addr_i)
				`SEQ_ENTRY_SEL_OFS: next_r.sel = wdata_i[IW-1:0];
				`SEQ_ENTRY_DATA_OFS:
					if (r.sel < r.count && wdata_i[`ENT_STEP_MSB:`ENT_STEP_LSB] >= `STEP_NUM_MIN
						&& wdata_i[`ENT_STEP_MSB:`ENT_STEP_LSB] <= `STEP_NUM_MAX)
					begin
						next_r.step[r.sel] = wdata_i[`ENT_STEP_MSB:`ENT_STEP_LSB];
						next_r.skip[r.sel] = wdata_i[`ENT_SKIP_BIT];
						next_r.hold[r.sel] = wdata_i[`ENT_HOLD_MSB:`ENT_HOLD_LSB];
					end
				`SEQ_CTRL_OFS:
				begin
					if (wdata_i[`CTRL_CLEAR_BIT])
						next_r.count = '0;
					else if (wdata_i[`CTRL_APPEND_BIT] && r.count < IW'(MAX_ENTRIES))
					begin
						next_r.step[r.count] = `STEP_NUM_MIN;
						next_r.skip[r.count] = 1'b0;
						next_r.hold[r.count] = `HOLD_PC_FC;
						next_r.count = r.count + 1'b1;
					end
					else if (wdata_i[`CTRL_REMOVE_BIT] && r.sel < r.count)
					begin
						// Shift later entries down one place
						for (int i = 0; i < MAX_ENTRIES - 1; i++)
							if (i >= int'(r.sel))
							begin
								next_r.step[i] = r.step[i+1];
								next_r.skip[i] = r.skip[i+1];
								next_r.hold[i] = r.hold[i+1];
							end
						next_r.count = r.count - 1'b1;
					end
				end
				default: ;
			endcase
		end
		// Run sequencing
		case (r.st)
			ST_READY:
				if (start_rise && r.count != '0)
				begin
					next_r.idx = '0;
					next_r.done = 1'b0;
					next_r.stopped = 1'b0;
					next_r.st = ST_FETCH;
				end
			ST_FETCH:
				if (r.idx >= r.count || r.idx >= IW'(MAX_ENTRIES))
				begin
					next_r.done = 1'b1;
					next_r.st = ST_READY;
				end
				else if (r.skip[r.idx])
					next_r.idx = r.idx + 1'b1;
				else
				begin
					next_r.cur_step = r.step[r.idx];
					next_r.go = 1'b1;
					next_r.st = ST_RUN;
				end
			ST_RUN:
				if (verdict_ev)
				begin
					h = r.hold[r.idx];
					if (h >= `HOLD_TIMED_BASE)
					begin
						// Timed hold ignores the verdict
						next_r.tenths = h - `HOLD_TIMED_BASE;
						if (next_r.tenths < `HOLD_TENTHS_MIN)
							next_r.tenths = `HOLD_TENTHS_MIN;
						if (next_r.tenths > `HOLD_TENTHS_MAX)
							next_r.tenths = `HOLD_TENTHS_MAX;
						next_r.tick = CW'(TICK_CYCLES - 1);
						next_r.st = ST_TIMED;
					end
					else
					begin
						if (r.vpass_sy[1])
							hold_it = (h <= `HOLD_PH_FC);
						else
						begin
							hold_it = (h == `HOLD_PH_FH) || (h == `HOLD_PC_FH);
							stop_it = (h == `HOLD_PH_FS) || (h == `HOLD_PC_FS);
						end
						if (stop_it)
						begin
							next_r.stopped = 1'b1;
							next_r.st = ST_READY;
						end
						else if (hold_it)
							next_r.st = ST_HOLD;
						else
						begin
							next_r.idx = r.idx + 1'b1;
							next_r.st = ST_FETCH;
						end
					end
				end
			ST_HOLD:
				if (start_rise)
				begin
					next_r.idx = r.idx + 1'b1;
					next_r.st = ST_FETCH;
				end
			ST_TIMED:
				// Tenth-second countdown from the programmed value
				if (r.tick != '0)
					next_r.tick = r.tick - 1'b1;
				else if (r.tenths <= 14'd1)
				begin
					next_r.idx = r.idx + 1'b1;
					next_r.st = ST_FETCH;
				end
				else
				begin
					next_r.tenths = r.tenths - 1'b1;
					next_r.tick = CW'(TICK_CYCLES - 1);
				end
			default: next_r.st = ST_READY;
		endcase
		// Busy flag registered beside the state so the port needs no decode
		next_r.running = (next_r.st != ST_READY);
	end

	////////////////////////////////////////////////////////////////////////
	// State register; list contents survive reset only as cleared
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			r <= '0;
		else
			r <= next_r;
	end

	// Outputs straight from flops
	assign rdata_o            = r.rdata;
	assign step_go_o          = r.go;
	assign stored_test_step_o = r.cur_step;
	assign running_o          = r.running;
	assign run_done_o         = r.done;
	assign run_stopped_o      = r.stopped;
endmodule : step_sequencer
`default_nettype wire

/* File: verif/op_model.sv */
// Operator START and step judgement model
`timescale 1ns/1ps
`default_nettype none
module op_model (
	// Clock
	input  wire logic clk_i,
	// Pins toward the sequencer
	output var logic  start_o,
	output var logic  valid_o,
	output var logic  pass_o
);
	// Idle levels from time zero
	initial
	begin
		{start_o, valid_o, pass_o} = '0;
	end
	// One-cycle START press
	task automatic press;
		@(posedge clk_i);
		start_o <= 1'b1;
		@(posedge clk_i);
		start_o <= 1'b0;
	endtask : press
	// Pass line held through the synchroniser, then inverted so stale values never look valid
	task automatic judge(input logic p);
		@(posedge clk_i);
		pass_o <= p;
		valid_o <= 1'b1;
		@(posedge clk_i);
		valid_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		pass_o <= ~p;
	endtask : judge
endmodule : op_model
`default_nettype wire

/* File: verif/step_sequencer_assertions.sv */
// Port checker for the step sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_chk (
	// Clock, reset, bus
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Run outputs
	input wire logic        step_go_o,
	input wire logic [6:0]  stored_test_step_o,
	input wire logic        running_o,
	input wire logic        run_done_o,
	input wire logic        run_stopped_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_go_pulse: assert property (step_go_o |=> !step_go_o) else $error("go too long");
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0) else $error("rdata not idle");
	a_go_running: assert property (step_go_o |-> running_o) else $error("go while ready");
	a_step_range: assert property (step_go_o |-> stored_test_step_o inside {[7'd1:7'd100]})
		else $error("step out of range");
	a_end_excl: assert property (!(run_done_o && run_stopped_o)) else $error("done and stopped");
	a_run_first: assert property ($rose(running_o) |-> ##[1:14] (step_go_o || !running_o))
		else $error("no first step");
	a_reset_quiet: assert property ($rose(nrst_i) |-> !running_o && !run_done_o)
		else $error("busy after reset");
	a_end_flag: assert property ($fell(running_o) |-> ##[0:1] (run_done_o || run_stopped_o))
		else $error("run end unflagged");
endmodule : seq_chk
////////////////////////////////
bind step_sequencer seq_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.step_go_o(step_go_o), .stored_test_step_o(stored_test_step_o), .running_o(running_o),
	.run_done_o(run_done_o), .run_stopped_o(run_stopped_o));
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the step sequencer
`timescale 1ns/1ps
`default_nettype none
`include "step_seq_map.svh"
module testbench;
	logic        clk_i = 1'b0;
	logic        nrst_i, wr_i, rd_i, go, st, vv, vp, rn, dn, sp;
	logic [3:0]  addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [6:0]  step;
	int          err_total, num_checks, n;
	// Status after the verdict, per hold code and [fail, pass]
	logic [7:0]  ex [6][2] = '{'{8'h3, 8'h3}, '{8'h40, 8'h3}, '{8'h2, 8'h3},
		'{8'h3, 8'h2}, '{8'h40, 8'h2}, '{8'h2, 8'h2}};
	always #12.5 clk_i = ~clk_i;
	op_model u_op (.clk_i(clk_i), .start_o(st), .valid_o(vv), .pass_o(vp));
	step_sequencer #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .start_i(st), .verdict_valid_i(vv),
		.verdict_pass_i(vp), .step_go_o(go), .stored_test_step_o(step), .running_o(rn), .run_done_o(dn),
		.run_stopped_o(sp));
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rd
	task automatic add(input logic [6:0] s, input logic k, input logic [13:0] h, input logic [3:0] i);
		wr(4'h0, 32'h2);
		wr(4'h2, {28'h0, i});
		wr(4'h3, {10'h0, h, k, s});
	endtask : add
	// Bounded wait for the next step launch
	task automatic wgo(input logic [6:0] s);
		for (n = 0; n < 60 && go !== 1'b1; n++)
			@(negedge clk_i);
		chk({go, step}, {1'b1, s});
	endtask : wgo
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	////////////////////////////////
	initial
	begin
		{nrst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(4'h4, 32'h0);
		rd(4'hf, 32'h0);
		for (int c = 0; c < 6; c++)
			for (int p = 0; p < 2; p++)
			begin
				wr(4'h0, 32'h4);
				add(7'd5, 1'b0, 14'(c), 4'h0);
				add(7'd6, 1'b0, 14'h5, 4'h1);
				u_op.press();
				wgo(7'd5);
				u_op.judge(p[0]);
				repeat (8) @(posedge clk_i);
				rd(4'h1, {24'h0, ex[c][p]});
				chk({rn, dn, sp}, {|ex[c][p][2:0], ex[c][p][7:6]});
				if (ex[c][p] != 8'h40)
				begin
					if (ex[c][p] == 8'h3)
						u_op.press();
					if (ex[c][p] == 8'h3)
						wgo(7'd6);
					chk({25'h0, step}, 32'h6);
					u_op.judge(1'b1);
					repeat (8) @(posedge clk_i);
					rd(4'h1, 32'h80);
					chk({rn, dn, sp}, 3'b010);
				end
				$display("row %0d %0d end", c, p);
			end
		// Skip, removal and a timed hold of five tenths
		wr(4'h0, 32'h4);
		add(7'd7, 1'b1, 14'h5, 4'h0);
		add(7'd8, 1'b0, `HOLD_TIMED_BASE + 14'd5, 4'h1);
		add(7'd9, 1'b0, 14'h5, 4'h2);
		add(7'd10, 1'b0, 14'h5, 4'h3);
		wr(4'h0, 32'h1);
		rd(4'h4, 32'h3);
		u_op.press();
		wgo(7'd8);
		u_op.judge(1'b0);
		wgo(7'd9);
		chk(n > 8 && n < 40, 1);
		u_op.judge(1'b1);
		repeat (8) @(posedge clk_i);
		rd(4'h1, 32'h80);
		$display("skip timed end");
		// Appends beyond the limit are refused
		wr(4'h0, 32'h4);
		repeat (11) wr(4'h0, 32'h2);
		rd(4'h4, 32'ha);
		// Step numbers outside 1..100 leave the entry as appended
		wr(4'h2, 32'h0);
		wr(4'h3, 32'h0000_0565);
		wr(4'h3, 32'h0000_0500);
		rd(4'h3, {10'h0, `HOLD_PC_FC, 1'b0, `STEP_NUM_MIN});
		$display("limit end");
		// START and list edits are refused while a run is busy
		wr(4'h0, 32'h4);
		add(7'd11, 1'b0, `HOLD_PH_FH, 4'h0);
		u_op.press();
		wgo(7'd11);
		u_op.press();
		wr(4'h0, 32'h4);
		repeat (6) @(posedge clk_i);
		rd(4'h1, 32'h2);
		rd(4'h4, 32'h1);
		u_op.judge(1'b0);
		repeat (4) @(posedge clk_i);
		rd(4'h1, 32'h3);
		// Reset in mid-run while holding: outputs and list cleared, idle START ignored
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(negedge clk_i);
		chk({go, rn, dn, sp, step}, 11'h0);
		rd(4'h4, 32'h0);
		u_op.press();
		repeat (6) @(posedge clk_i);
		rd(4'h1, 32'h0);
		chk({go, rn, dn, sp}, 4'h0);
		$display("reset end");
		conclude();
	end
	// Watchdog: about twenty-five times the expected run
	initial
	begin
		#500000;
		err_total++;
		conclude();
	end
endmodule : testbench
`default_nettype wire
